/* File: src/efc_pkg.sv */
// Constants, state codes and byte classifier for the API frame codec.
// Assumes one clock domain; imported whole by every design module.
`default_nettype none

package efc_pkg;

    localparam logic [7:0] DELIM          = 8'h7E;
    localparam logic [7:0] ESC            = 8'h7D;
    localparam logic [7:0] XON            = 8'h11;
    localparam logic [7:0] XOFF           = 8'h13;
    localparam logic [7:0] ESC_MASK       = 8'h20;
    localparam logic [7:0] SUM_GOOD       = 8'hFF;
    localparam logic [7:0] LEN_HI_SHORT   = 8'h00;

    localparam logic [2:0] MODE_PLAIN     = 3'h1;
    localparam logic [2:0] MODE_ESC       = 3'h2;

    localparam logic [7:0] TYPE_LOCAL_CMD = 8'h08;
    localparam logic [7:0] TYPE_CMD_RSP   = 8'h88;
    localparam logic [7:0] TYPE_STATUS    = 8'h8A;
    localparam logic [7:0] REASON_SUM     = 8'h01;
    localparam logic [7:0] REASON_FORMAT  = 8'h02;

    localparam logic [15:0] IDX_TYPE      = 16'h0000;
    localparam logic [15:0] IDX_ID        = 16'h0001;
    localparam logic [15:0] IDX_NAME_HI   = 16'h0002;
    localparam logic [15:0] IDX_NAME_LO   = 16'h0003;
    localparam logic [15:0] CMD_MIN_LEN   = 16'h0004;

    localparam logic [2:0] VAL_BYTES      = 3'h4;
    localparam logic [3:0] RSP_HDR        = 4'h5;
    localparam logic [3:0] ERR_LEN        = 4'h2;
    localparam int         TBUF_LEN       = 9;
    localparam int         FIFO_WIDTH     = 8;
    localparam int         FIFO_DEPTH     = 8;

    typedef enum logic [4:0] {
        R_IDLE   = 5'h01,
        R_LEN_HI = 5'h02,
        R_LEN_LO = 5'h04,
        R_DATA   = 5'h08,
        R_SUM    = 5'h10
    } efc_rx_state_t;

    typedef enum logic [5:0] {
        T_IDLE   = 6'h01,
        T_DELIM  = 6'h02,
        T_LEN_HI = 6'h04,
        T_LEN_LO = 6'h08,
        T_DATA   = 6'h10,
        T_SUM    = 6'h20
    } efc_tx_state_t;

    function automatic logic efc_needs_esc(input logic [7:0] b);
        efc_needs_esc = (b == DELIM) || (b == ESC) || (b == XON) || (b == XOFF);
    endfunction

endpackage

`default_nettype wire

/* File: src/efc_fifo.sv */
// Synchronous valid/ready FIFO with parameter width and depth.
// Assumes one clock and synchronous active-high reset; depth a power of two.
`default_nettype none

module efc_fifo
    import efc_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;

    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;

    // Count is one bit wider than the pointers so full differs from empty
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ff];

    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_ff] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ff <= wr_ff + 1'b1;
            if (do_rd)
                rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    a_fifo_no_overrun : assert property (@(posedge clk) disable iff (rst)
        !in_ready |-> cnt_ff == (AW+1)'(DEPTH))
        else $error("fifo refused while not full");

endmodule

`default_nettype wire

/* File: src/efc_frame_codec.sv */
// Device-side API frame codec: parses plain or escaped frames from the host,
// issues local parameter commands, and sends responses and status frames.
// Assumes the parameter store answers each command through cmd_done.
`default_nettype none

// Contract
// RQ1 - Escaped mode: unescaped delimiter restarts reception, discarding partial frame silently.
// RQ2 - Every frame starts with the fixed delimiter byte; receiver hunts for it.
// RQ3 - Escaping sends the escape byte, then the original XORed with the mask.
// RQ4 - Delimiter, escape, XON and XOFF are escaped wherever they follow the delimiter.
// RQ5 - Escaping applies to both directions when the escaped mode is selected.
// RQ6 - Length and checksum cover unescaped data bytes only, never escape bytes.
// RQ7 - Two length bytes follow the delimiter, high first, checksum excluded.
// RQ8 - First data byte is frame type; one checksum byte ends the frame.
// RQ9 - Multi-byte values travel most significant byte first.
// RQ10 - Sent checksum is all-ones minus low byte of data sum.
// RQ11 - Received frame valid only when data plus checksum sums to all-ones.
// RQ12 - A frame failing its checksum is discarded and never acted on.
// RQ13 - Local command frames query or set a parameter, effective after execution.
// RQ14 - Correlation identifier zero suppresses the command response frame.
// RQ15 - Host places exactly two command-name characters after the identifier.
// RQ16 - Value bytes present means set; none present means query.
// RQ17 - A bad or failed frame is answered with a status frame giving reason.
// RQ18 - Mode value 2 selects escaped, 1 plain; escaped only on async port.
// RQ19 - Receiver drops escape bytes and unmasks the next before length and sum.
module efc_frame_codec
    import efc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [2:0]  interface_mode_setting,
    input  wire logic        uart_port,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    output logic             cmd_valid,
    output logic      [15:0] cmd_name,
    output logic             cmd_write,
    output logic      [31:0] cmd_wdata,
    output logic      [2:0]  cmd_wlen,
    input  wire logic        cmd_done,
    input  wire logic [7:0]  cmd_status,
    input  wire logic [31:0] cmd_rdata,
    input  wire logic [2:0]  cmd_rlen,
    output logic             frame_good,
    output logic      [7:0]  frame_type
);
    efc_rx_state_t rstate_ff;
    efc_rx_state_t nxt_rstate;
    efc_tx_state_t tstate_ff;
    efc_tx_state_t nxt_tstate;

    logic        esc_ff;
    logic [15:0] len_ff;
    logic [15:0] cnt_ff;
    logic [7:0]  sum_ff;
    logic [7:0]  type_ff;
    logic [7:0]  id_ff;
    logic [15:0] name_ff;
    logic [31:0] val_ff;
    logic [2:0]  vlen_ff;
    logic        over_ff;
    logic        cmd_wait_ff;
    logic        cmd_valid_ff;
    logic        frame_good_ff;
    logic [15:0] cmd_name_ff;
    logic [31:0] cmd_wdata_ff;
    logic [2:0]  cmd_wlen_ff;
    logic [7:0]  frame_type_ff;

    logic [7:0]  tbuf [0:TBUF_LEN-1];
    logic [3:0]  tlen_ff;
    logic [3:0]  tidx_ff;
    logic [7:0]  tsum_ff;
    logic        tesc_ff;
    logic        fifo_in_ready;
    logic        fifo_in_valid;
    logic [7:0]  fifo_in_data;

    // Mode decode; the escaped variant exists only on the async port
    wire esc_mode = (interface_mode_setting == MODE_ESC) && uart_port;    // RQ18
    wire api_on   = esc_mode || (interface_mode_setting == MODE_PLAIN);   // RQ18

    // Receive decode
    wire       take       = rx_valid && rx_ready;
    wire       in_frame   = (rstate_ff != R_IDLE);
    wire       esc_in     = esc_mode && !esc_ff && in_frame && (rx_data == ESC);     // RQ19
    wire       restart_in = take && esc_mode && !esc_ff && in_frame
                            && (rx_data == DELIM);                                   // RQ1
    wire       start_in   = take && !in_frame && api_on && (rx_data == DELIM);       // RQ2
    wire [7:0] rx_val     = esc_ff ? (rx_data ^ ESC_MASK) : rx_data;                 // RQ3 RQ19
    wire       use_byte   = take && api_on && in_frame && !esc_in && !restart_in;    // RQ6
    wire       nxt_esc    = take ? esc_in : (esc_ff && api_on);
    wire [15:0] len_full  = {len_ff[15:8], rx_val};
    wire [15:0] cnt_inc   = cnt_ff + 16'h0001;
    wire [7:0] sum_chk    = sum_ff + rx_val;

    // End-of-frame outcome
    wire       frame_end  = use_byte && (rstate_ff == R_SUM);
    wire       sum_ok     = (sum_chk == SUM_GOOD);                                   // RQ11
    wire       is_cmd     = (type_ff == TYPE_LOCAL_CMD) && (len_ff != 16'h0000);
    wire       fmt_ok     = (len_ff >= CMD_MIN_LEN) && !over_ff;
    wire       go_cmd     = frame_end && sum_ok && is_cmd && fmt_ok;                 // RQ12 RQ13
    wire       go_good    = frame_end && sum_ok && !is_cmd;
    wire       go_err     = frame_end && !(sum_ok && (!is_cmd || fmt_ok));           // RQ17
    wire [7:0] err_reason = sum_ok ? REASON_FORMAT : REASON_SUM;
    wire       go_rsp     = cmd_wait_ff && cmd_done && (id_ff != 8'h00);             // RQ14

    // Response value left-aligned so it leaves high byte first
    wire [2:0]  rlen_c  = (cmd_rlen > VAL_BYTES) ? VAL_BYTES : cmd_rlen;
    wire [2:0]  rpad    = VAL_BYTES - rlen_c;
    wire [31:0] rsp_al  = cmd_rdata << {rpad, 3'b000};                               // RQ9

    // Receive stalls while a command is open or a reply is going out
    assign rx_ready = !cmd_wait_ff && (tstate_ff == T_IDLE);

    always_comb
    begin
        nxt_rstate = rstate_ff;
        if (!api_on)
            nxt_rstate = R_IDLE;
        else if (restart_in || start_in)
            nxt_rstate = R_LEN_HI;                                                   // RQ1 RQ2
        else if (use_byte)
        begin
            unique case (rstate_ff)
                R_IDLE:   nxt_rstate = R_IDLE;
                R_LEN_HI: nxt_rstate = R_LEN_LO;                                     // RQ7
                R_LEN_LO: nxt_rstate = (len_full == 16'h0000) ? R_SUM : R_DATA;
                R_DATA:   nxt_rstate = (cnt_inc == len_ff) ? R_SUM : R_DATA;         // RQ8
                R_SUM:    nxt_rstate = R_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rstate_ff <= R_IDLE;
            esc_ff    <= 1'b0;
            len_ff    <= '0;
            cnt_ff    <= '0;
            sum_ff    <= '0;
            type_ff   <= '0;
            id_ff     <= '0;
            name_ff   <= '0;
            val_ff    <= '0;
            vlen_ff   <= '0;
            over_ff   <= 1'b0;
        end
        else
        begin
            rstate_ff <= nxt_rstate;
            esc_ff    <= nxt_esc;
            if (restart_in || start_in)
            begin
                // Partial frame is dropped without any report
                cnt_ff  <= '0;                                                       // RQ1
                sum_ff  <= '0;
                type_ff <= '0;
                val_ff  <= '0;
                vlen_ff <= '0;
                over_ff <= 1'b0;
            end
            else if (use_byte && rstate_ff == R_LEN_HI)
                len_ff[15:8] <= rx_val;                                              // RQ7
            else if (use_byte && rstate_ff == R_LEN_LO)
                len_ff[7:0] <= rx_val;
            else if (use_byte && rstate_ff == R_DATA)
            begin
                sum_ff <= sum_chk;                                                   // RQ6
                cnt_ff <= cnt_inc;
                if (cnt_ff == IDX_TYPE)
                    type_ff <= rx_val;                                               // RQ8
                if (cnt_ff == IDX_ID)
                    id_ff <= rx_val;
                if (cnt_ff == IDX_NAME_HI)
                    name_ff[15:8] <= rx_val;
                if (cnt_ff == IDX_NAME_LO)
                    name_ff[7:0] <= rx_val;
                if (cnt_ff >= CMD_MIN_LEN)
                begin
                    val_ff <= {val_ff[23:0], rx_val};                                // RQ9
                    if (vlen_ff == VAL_BYTES)
                        over_ff <= 1'b1;
                    else
                        vlen_ff <= vlen_ff + 3'h1;
                end
            end
        end
    end

    // Command issue; the parameter store applies a write when it completes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmd_wait_ff   <= 1'b0;
            cmd_valid_ff  <= 1'b0;
            frame_good_ff <= 1'b0;
            cmd_name_ff   <= '0;
            cmd_wdata_ff  <= '0;
            cmd_wlen_ff   <= '0;
            frame_type_ff <= '0;
        end
        else
        begin
            cmd_valid_ff  <= go_cmd;                                                 // RQ13
            frame_good_ff <= go_good;
            if (go_cmd)
            begin
                cmd_wait_ff  <= 1'b1;
                cmd_name_ff  <= name_ff;
                cmd_wdata_ff <= val_ff;
                cmd_wlen_ff  <= vlen_ff;                                             // RQ16
            end
            else if (cmd_done)
                cmd_wait_ff <= 1'b0;
            if (go_cmd || go_good)
                frame_type_ff <= type_ff;
        end
    end

    assign cmd_valid  = cmd_valid_ff;
    assign cmd_name   = cmd_name_ff;
    assign cmd_wdata  = cmd_wdata_ff;
    assign cmd_wlen   = cmd_wlen_ff;
    assign cmd_write  = (cmd_wlen_ff != 3'h0);                                       // RQ16
    assign frame_good = frame_good_ff;
    assign frame_type = frame_type_ff;

    // Reply buffer holds unescaped frame data only
    always_ff @(posedge clk)
    begin
        if (go_err)
        begin
            tbuf[0] <= TYPE_STATUS;                                                  // RQ17
            tbuf[1] <= err_reason;
        end
        else if (go_rsp)
        begin
            tbuf[0] <= TYPE_CMD_RSP;
            tbuf[1] <= id_ff;
            tbuf[2] <= name_ff[15:8];
            tbuf[3] <= name_ff[7:0];
            tbuf[4] <= cmd_status;
            for (int k = 0; k < 4; k++)
                tbuf[int'(RSP_HDR) + k] <= rsp_al[31 - 8*k -: 8];                    // RQ9
        end
    end

    // Transmit selection
    wire [7:0] tx_chk = SUM_GOOD - tsum_ff;                                          // RQ10
    wire [7:0] tx_cur = (tstate_ff == T_LEN_HI) ? LEN_HI_SHORT :
                        (tstate_ff == T_LEN_LO) ? {4'h0, tlen_ff} :                  // RQ7
                        (tstate_ff == T_DATA)   ? tbuf[tidx_ff] :
                        (tstate_ff == T_SUM)    ? tx_chk : DELIM;
    wire tx_esc_now = esc_mode && !tesc_ff && (tstate_ff != T_DELIM)
                      && (tstate_ff != T_IDLE) && efc_needs_esc(tx_cur);             // RQ4 RQ5
    wire fifo_wr    = fifo_in_valid && fifo_in_ready;
    wire tx_step    = fifo_wr && !tx_esc_now;
    wire [3:0] tidx_inc = tidx_ff + 4'h1;

    assign fifo_in_valid = (tstate_ff != T_IDLE);
    assign fifo_in_data  = tx_esc_now ? ESC :
                           (tesc_ff ? (tx_cur ^ ESC_MASK) : tx_cur);                 // RQ3

    always_comb
    begin
        nxt_tstate = tstate_ff;
        unique case (tstate_ff)
            T_IDLE:   if (go_err || go_rsp) nxt_tstate = T_DELIM;                    // RQ2
            T_DELIM:  if (tx_step) nxt_tstate = T_LEN_HI;
            T_LEN_HI: if (tx_step) nxt_tstate = T_LEN_LO;
            T_LEN_LO: if (tx_step) nxt_tstate = T_DATA;
            T_DATA:   if (tx_step && tidx_inc == tlen_ff) nxt_tstate = T_SUM;
            T_SUM:    if (tx_step) nxt_tstate = T_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tstate_ff <= T_IDLE;
            tlen_ff   <= '0;
            tidx_ff   <= '0;
            tsum_ff   <= '0;
            tesc_ff   <= 1'b0;
        end
        else
        begin
            tstate_ff <= nxt_tstate;
            if (fifo_wr)
                tesc_ff <= tx_esc_now;                                               // RQ3
            if (tstate_ff == T_IDLE)
            begin
                tidx_ff <= '0;
                tsum_ff <= '0;
                if (go_err)
                    tlen_ff <= ERR_LEN;
                else if (go_rsp)
                    tlen_ff <= RSP_HDR + {1'b0, rlen_c};
            end
            else if (tx_step && tstate_ff == T_DATA)
            begin
                tsum_ff <= tsum_ff + tx_cur;                                         // RQ6 RQ10
                tidx_ff <= tidx_inc;
            end
        end
    end

    efc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_delim_restart : assert property (restart_in |=> rstate_ff == R_LEN_HI && cnt_ff == 16'h0000) // RQ1
        else $error("unescaped delimiter did not restart");
    a_idle_hunt : assert property (take && !in_frame && rx_data != DELIM |=> !in_frame) // RQ2
        else $error("left idle without delimiter");
    a_tx_delim_first : assert property (tstate_ff == T_IDLE && (go_err || go_rsp) // RQ2
        |=> fifo_in_valid && fifo_in_data == DELIM)
        else $error("reply not opened by delimiter");
    a_esc_pair : assert property (fifo_wr && tx_esc_now // RQ3
        |-> fifo_in_data == ESC ##1 fifo_in_data == ($past(tx_cur) ^ ESC_MASK))
        else $error("escape not followed by masked byte");
    a_esc_reserved : assert property (esc_mode && fifo_in_valid && tstate_ff != T_DELIM // RQ4 RQ5
        && !tesc_ff && efc_needs_esc(tx_cur) |-> fifo_in_data == ESC)
        else $error("reserved byte sent unescaped");
    a_plain_raw : assert property (!esc_mode && fifo_in_valid |-> fifo_in_data == tx_cur) // RQ18
        else $error("plain mode altered a byte");
    a_rx_unescape : assert property (use_byte && esc_ff && rstate_ff == R_DATA // RQ19 RQ6
        |=> sum_ff == 8'($past(sum_ff) + ($past(rx_data) ^ ESC_MASK)))
        else $error("escaped byte not restored in sum");
    a_len_order : assert property (use_byte && rstate_ff == R_LEN_LO // RQ7
        |=> len_ff == {$past(len_ff[15:8]), $past(rx_val)})
        else $error("length not high byte first");
    a_bad_sum_drop : assert property (frame_end && !sum_ok |=> !cmd_valid ##1 !cmd_valid) // RQ11 RQ12
        else $error("bad frame acted upon");
    a_cmd_issue : assert property (frame_end && sum_ok && is_cmd && fmt_ok // RQ13 RQ16
        |=> cmd_valid && cmd_write == (cmd_wlen != 3'h0) && cmd_wait_ff)
        else $error("good command not issued");
    a_zero_id_quiet : assert property (cmd_wait_ff && cmd_done && id_ff == 8'h00 // RQ14
        |=> tstate_ff == T_IDLE)
        else $error("response sent for zero identifier");
    a_tx_checksum : assert property (tstate_ff == T_SUM |-> 8'(tsum_ff + tx_cur) == SUM_GOOD) // RQ10
        else $error("sent checksum wrong");
    a_err_reply : assert property (frame_end && !sum_ok // RQ17
        |=> tstate_ff == T_DELIM && tbuf[1] == REASON_SUM)
        else $error("no status frame for bad checksum");

    c_cmd_response : cover property (go_rsp);
    c_esc_restart  : cover property (restart_in);
    c_bad_sum      : cover property (frame_end && !sum_ok);
    c_tx_escape    : cover property (fifo_wr && tx_esc_now);

endmodule

`default_nettype wire

/* File: bench/efc_host_model.sv */
// Host-side model: frames and sends bytes to the codec, sinks its replies.
// Assumes the codec's clock; the bench calls the tasks hierarchically.
`default_nettype none

module efc_host_model
    import efc_pkg::*;
(
    input  wire logic       clk,
    output logic            rx_valid = 1'h0,
    output logic      [7:0] rx_data  = 8'hA5,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready = 1'h1
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] efc_hq_t[$];
    efc_hq_t    got;
    logic       stall = 1'h0;
    logic [3:0] cnt_ff = 4'h0;

    // Data is given unescaped: type, id, two name bytes, value
    function automatic efc_hq_t frame(input efc_hq_t d, input bit esc, input bit bad);
        efc_hq_t    raw;
        efc_hq_t    o;
        logic [7:0] s;
        s = 8'h00;
        foreach (d[i])
            s += d[i];
        raw = {8'h00, 8'(d.size()), d, (8'hFF - s) ^ {7'h00, bad}};
        o = {DELIM};
        foreach (raw[i])
            if (esc && (raw[i] inside {DELIM, ESC, XON, XOFF}))
                o = {o, ESC, raw[i] ^ ESC_MASK};
            else
                o.push_back(raw[i]);
        return o;
    endfunction

    // Valid held across bytes so a frame goes back to back
    task automatic send_frame(input efc_hq_t q, output bit ok);
        int n;
        ok = 1'h1;
        foreach (q[i])
        begin
            rx_valid <= 1'h1;
            rx_data  <= q[i];
            for (n = 0; n < 200; n++)
            begin
                @(posedge clk);
                if (rx_ready === 1'h1)
                    break;
            end
            if (n == 200)
                ok = 1'h0;
        end
        rx_valid <= 1'h0;
        rx_data  <= ~q[q.size() - 1];
    endtask

    always @(posedge clk)
    begin
        cnt_ff   <= cnt_ff + 4'h1;
        tx_ready <= !stall || cnt_ff[1];
        if (tx_valid === 1'h1 && tx_ready)
            got.push_back(tx_data);
    end
endmodule

`default_nettype wire

/* File: bench/efc_frame_codec_test.sv */
// Testbench for the frame codec; the bench plays the parameter store.
// Assumes one 20 MHz clock and the host model on the serial side.
`default_nettype none

module efc_frame_codec_test
    import efc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] efc_tq_t[$];
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [2:0]  mode = MODE_PLAIN;
    logic        uart = 1'h1;
    logic        cmd_done = 1'h0;
    logic [7:0]  cmd_status = 8'h00;
    logic [31:0] cmd_rdata = 32'h0;
    logic [2:0]  cmd_rlen = 3'h0;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_write, frame_good;
    logic [7:0]  rx_data, tx_data, frame_type;
    logic [15:0] cmd_name;
    logic [31:0] cmd_wdata;
    logic [2:0]  cmd_wlen;
    int          num_errors = 0;
    int          tests_run = 0;
    int          n_cmd = 0;
    int          n_good = 0;
    bit          ok;

    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        if (cmd_valid === 1'h1)
            n_cmd++;
        if (frame_good === 1'h1)
            n_good++;
    end

    efc_frame_codec i_efc_frame_codec (.clk(clk), .rst(rst), .interface_mode_setting(mode),
        .uart_port(uart), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid),
        .cmd_name(cmd_name), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_wlen(cmd_wlen), .cmd_done(cmd_done), .cmd_status(cmd_status),
        .cmd_rdata(cmd_rdata), .cmd_rlen(cmd_rlen), .frame_good(frame_good),
        .frame_type(frame_type));

    efc_host_model i_efc_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic send(input efc_tq_t q);
        i_efc_host_model.send_frame(q, ok);
        if (!ok)
        begin
            num_errors++;
            complete_run();
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic expect_bytes(input efc_tq_t exp);
        int n;
        for (n = 0; n < 400 && i_efc_host_model.got.size() < exp.size(); n++)
            @(posedge clk);
        if (n == 400)
        begin
            num_errors++;
            complete_run();
        end
        repeat (20) @(posedge clk);
        check("reply size", exp.size(), i_efc_host_model.got.size());
        foreach (exp[i])
            check("reply byte", exp[i], i_efc_host_model.got[i]);
        i_efc_host_model.got.delete();
    endtask

    task automatic answer(input logic [7:0] st, input logic [31:0] rd,
                          input logic [2:0] rl, input efc_tq_t exp);
        cmd_status <= st;
        cmd_rdata  <= rd;
        cmd_rlen   <= rl;
        cmd_done   <= 1'h1;
        @(posedge clk);
        cmd_done   <= 1'h0;
        expect_bytes(exp);
    endtask

    task automatic t_plain_set();
        int c;
        c = n_cmd;
        send(i_efc_host_model.frame('{8'h08, 8'h01, 8'h41, 8'h42, 8'h12, 8'h34}, 0, 0));
        check("cmd pulses", c + 1, n_cmd);
        check("name", 16'h4142, cmd_name);
        check("write", 1'h1, cmd_write);
        check("value", 32'h1234, cmd_wdata);
        check("value size", 3'h2, cmd_wlen);
        answer(8'h00, 32'h0, 3'h0,
            i_efc_host_model.frame('{8'h88, 8'h01, 8'h41, 8'h42, 8'h00}, 0, 0));
        $display("test plain_set done");
    endtask

    // Junk and a cut-off frame first; reply is stalled by the host
    task automatic t_esc_query();
        int c;
        c = n_cmd;
        mode <= MODE_ESC;
        i_efc_host_model.stall <= 1'h1;
        send('{8'h55, 8'h7E, 8'h00, 8'h09, 8'h08, 8'h01});
        send(i_efc_host_model.frame('{8'h08, 8'h11, 8'h7E, 8'h7D}, 1, 0));
        check("cmd pulses", c + 1, n_cmd);
        check("name", 16'h7E7D, cmd_name);
        check("write", 1'h0, cmd_write);
        answer(8'h13, 32'h00117E42, 3'h3, i_efc_host_model.frame(
            '{8'h88, 8'h11, 8'h7E, 8'h7D, 8'h13, 8'h11, 8'h7E, 8'h42}, 1, 0));
        i_efc_host_model.stall <= 1'h0;
        mode <= MODE_PLAIN;
        $display("test esc_query done");
    endtask

    task automatic t_bad_frames();
        int c;
        c = n_cmd;
        send(i_efc_host_model.frame('{8'h08, 8'h01, 8'h41, 8'h42}, 0, 1));
        expect_bytes(i_efc_host_model.frame('{8'h8A, 8'h01}, 0, 0));
        send(i_efc_host_model.frame('{8'h08, 8'h01, 8'h41}, 0, 0));
        expect_bytes(i_efc_host_model.frame('{8'h8A, 8'h02}, 0, 0));
        check("cmd pulses", c, n_cmd);
        $display("test bad_frames done");
    endtask

    task automatic t_silent_other();
        int c;
        int g;
        c = n_cmd;
        g = n_good;
        send(i_efc_host_model.frame('{8'h08, 8'h00, 8'h41, 8'h42, 8'h05}, 0, 0));
        check("value", 32'h5, cmd_wdata);
        answer(8'h00, 32'h0, 3'h0, '{});
        send(i_efc_host_model.frame('{8'h17, 8'h01, 8'h02}, 0, 0));
        check("good pulses", g + 1, n_good);
        check("type", 8'h17, frame_type);
        check("cmd pulses", c + 1, n_cmd);
        // Escaped mode off the async port leaves the codec deaf
        uart <= 1'h0;
        mode <= MODE_ESC;
        send(i_efc_host_model.frame('{8'h17, 8'h01, 8'h02}, 1, 0));
        check("good pulses", g + 1, n_good);
        $display("test silent_other done");
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_plain_set();
        t_esc_query();
        t_bad_frames();
        t_silent_other();
        complete_run();
    end
endmodule

`default_nettype wire
